// ===== rtl/rcv_tuning_pkg.sv
package rcv_tuning_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [15:0] MANUAL_RECEIVER_TUNING_IDX = 16'h630d; // Printed offset (index)
    localparam logic [17:0] MANUAL_RECEIVER_TUNING_ADDR = 18'h18c34; // Byte address = 4 * index
    localparam logic [7:0]  MANUAL_RECEIVER_TUNING_RST = 8'h00;  // Value after reset
    localparam logic [7:0]  MANUAL_RECEIVER_TUNING_WMASK = 8'h7f; // Bit 7 reserved
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MILLER_FILTER_FAST_BIT      = 6;
    localparam int SIGNAL_OUT_DELAY_ENABLE_BIT = 5;
    localparam int PARITY_OFF_BIT              = 4;
    localparam int WIDE_RECOVERY_LOOP_BIT      = 3;
    localparam int MANUAL_CORNER_SELECT_BIT    = 2;
    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [3:0] SIGNAL_OUT_SOURCE_DELAYED = 4'hc; // Source 1100b
    typedef enum logic [1:0] {
        CORNER_106K = 2'h0,
        CORNER_212K = 2'h1,
        CORNER_424K = 2'h2,
        CORNER_848K = 2'h3
    } corner_t;
    // Receive mode codes used by the automatic corner choice
    localparam logic [1:0] RX_MODE_106K = 2'h0;
    localparam logic [1:0] RX_MODE_212K = 2'h1;
    localparam logic [1:0] RX_MODE_424K = 2'h2;
    localparam logic [1:0] RX_MODE_848K = 2'h3;
endpackage : rcv_tuning_pkg

// ===== rtl/tuning_if.sv
`timescale 1ns/10ps
// Control fields passed from the register slice to the main logic
interface tuning_if;
    logic [7:0] value; // Current register contents
    modport source (output value);
    modport sink   (input  value);
endinterface : tuning_if

// ===== rtl/tuning_reg_slice.sv
`timescale 1ns/10ps
// Holds the register contents; writes with the write mask applied
module tuning_reg_slice (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    tuning_if.source        tune
);
    logic [7:0] reg_q; // Stored contents
    logic [7:0] reg_d; // Next contents

    // Next value: masked write, reserved bit stays zero
    always_comb begin
        reg_d = reg_q;
        if (wr_en_i) begin
            reg_d = wr_data_i & rcv_tuning_pkg::MANUAL_RECEIVER_TUNING_WMASK;
        end
    end

    // Register with asynchronous reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_q <= rcv_tuning_pkg::MANUAL_RECEIVER_TUNING_RST;
        end else begin
            reg_q <= reg_d;
        end
    end

    assign tune.value = reg_q;
endmodule : tuning_reg_slice

// ===== rtl/receiver_manual_tuning_reg.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Receiver manual tuning register with Avalon-MM slave and control outputs
module receiver_manual_tuning_reg (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [17:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    // Context from neighbouring logic
    input  wire logic [3:0]  signal_out_source_i,
    input  wire logic [1:0]  rx_mode_i,
    input  wire logic [6:0]  tx_phase_delay_i,
    input  wire logic [1:0]  tx_extra_wait_i,
    // Transmit / receive framing
    input  wire logic        secure_if_raw_i,
    input  wire logic        rx_bit_i,
    input  wire logic        rx_bit_valid_i,
    input  wire logic        rx_parity_slot_i,
    input  wire logic        rx_parity_expected_i,
    // Controls to the analog chain, parity flags, secure output and received data
    output logic             miller_filter_fast_o,
    output logic             wide_recovery_loop_o,
    output logic      [1:0]  highpass_corner_o,
    output logic             parity_insert_o,
    output logic             parity_check_o,
    output logic             secure_if_out_o,
    output logic             rx_data_bit_o,
    output logic             rx_data_valid_o,
    output logic             rx_parity_error_o
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    tuning_if tune ();
    logic        hit;      // Address decodes to the register
    logic        pending_q; // A request has been answered this cycle
    logic        pending_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  resp_q;
    logic [1:0]  resp_d;
    logic        wait_q;    // Registered waitrequest, high while idle
    logic        wait_d;
    logic        wr_en;
    logic [7:0]  cfg;

    assign hit   = (avs_address_i == rcv_tuning_pkg::MANUAL_RECEIVER_TUNING_ADDR);
    // Write lands only at the edge where waitrequest is seen low
    assign wr_en = avs_write_i && pending_q && hit && avs_byteenable_i[0];
    assign cfg   = tune.value;

    tuning_reg_slice u_slice (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_en),
        .wr_data_i (avs_writedata_i[7:0]),
        .tune      (tune.source)
    );

    // One wait cycle, then answer; unmapped reads return zero, SLVERR
    always_comb begin
        pending_d = 1'b0;
        wait_d    = 1'b1;
        rdata_d   = rdata_q;
        resp_d    = resp_q;
        if ((avs_read_i || avs_write_i) && !pending_q) begin
            pending_d = 1'b1;
            wait_d    = 1'b0; // Answer in the next cycle
            rdata_d   = (avs_read_i && hit) ? {24'h000000, cfg} : 32'h00000000;
            resp_d    = hit ? 2'h0 : 2'h2;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pending_q <= 1'b0;
            wait_q    <= 1'b1;
            rdata_q   <= 32'h00000000;
            resp_q    <= 2'h0;
        end else begin
            pending_q <= pending_d;
            wait_q    <= wait_d;
            rdata_q   <= rdata_d;
            resp_q    <= resp_d;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_response_o    = resp_q;
    assign avs_waitrequest_o = wait_q;

    // ----------------------------------------
    // Delay engine for the secure interface output
    // ----------------------------------------
    logic [8:0] delay_len;   // Total delay in clocks
    logic [8:0] dly_cnt_q;
    logic [8:0] dly_cnt_d;
    logic       dly_level_q; // Level waiting to be released
    logic       dly_level_d;
    logic       sig_q;
    logic       sig_d;
    logic       delay_on;

    // Extra wait is the coarse part, phase the fine part
    assign delay_len = {tx_extra_wait_i, tx_phase_delay_i};
    assign delay_on  = cfg[rcv_tuning_pkg::SIGNAL_OUT_DELAY_ENABLE_BIT] &&
                       (signal_out_source_i == rcv_tuning_pkg::SIGNAL_OUT_SOURCE_DELAYED);

    // Edge is held then released after delay_len clocks; new edges restart the count
    always_comb begin
        dly_cnt_d   = dly_cnt_q;
        dly_level_d = dly_level_q;
        sig_d       = sig_q;
        if (!delay_on) begin
            sig_d       = secure_if_raw_i;
            dly_level_d = secure_if_raw_i;
            dly_cnt_d   = 9'h000;
        end else if (secure_if_raw_i != dly_level_q) begin
            dly_level_d = secure_if_raw_i;
            dly_cnt_d   = delay_len;
            if (delay_len == 9'h000) begin
                sig_d = secure_if_raw_i;
            end
        end else if (dly_cnt_q != 9'h000) begin
            dly_cnt_d = dly_cnt_q - 9'h001;
            if (dly_cnt_q == 9'h001) begin
                sig_d = dly_level_q;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dly_cnt_q   <= 9'h000;
            dly_level_q <= 1'b0;
            sig_q       <= 1'b0;
        end else begin
            dly_cnt_q   <= dly_cnt_d;
            dly_level_q <= dly_level_d;
            sig_q       <= sig_d;
        end
    end

    // ----------------------------------------
    // Analog controls and parity handling
    // ----------------------------------------
    logic [1:0] auto_corner;
    logic [1:0] corner_d;
    logic       fast_q;
    logic       wide_q;
    logic [1:0] corner_q;
    logic       par_ins_q;
    logic       par_chk_q;
    logic       rx_bit_q;
    logic       rx_val_q;
    logic       rx_err_q;
    logic       rx_val_d;
    logic       rx_err_d;
    logic       parity_off;

    assign parity_off = cfg[rcv_tuning_pkg::PARITY_OFF_BIT];

    // Automatic corner follows the receive rate
    always_comb begin
        case (rx_mode_i)
            rcv_tuning_pkg::RX_MODE_106K: auto_corner = rcv_tuning_pkg::CORNER_106K;
            rcv_tuning_pkg::RX_MODE_212K: auto_corner = rcv_tuning_pkg::CORNER_212K;
            rcv_tuning_pkg::RX_MODE_424K: auto_corner = rcv_tuning_pkg::CORNER_424K;
            default:                      auto_corner = rcv_tuning_pkg::CORNER_848K;
        endcase
        if (cfg[rcv_tuning_pkg::MANUAL_CORNER_SELECT_BIT]) begin
            corner_d = cfg[1:0];
        end else begin
            corner_d = auto_corner;
        end
    end

    // Parity slot: dropped as check when enabled, passed as data when off
    always_comb begin
        rx_val_d = 1'b0;
        rx_err_d = 1'b0;
        if (rx_bit_valid_i) begin
            if (rx_parity_slot_i && !parity_off) begin
                rx_err_d = (rx_bit_i != rx_parity_expected_i);
            end else begin
                rx_val_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fast_q    <= 1'b0;
            wide_q    <= 1'b0;
            corner_q  <= 2'h0;
            par_ins_q <= 1'b1;
            par_chk_q <= 1'b1;
            rx_bit_q  <= 1'b0;
            rx_val_q  <= 1'b0;
            rx_err_q  <= 1'b0;
        end else begin
            fast_q    <= cfg[rcv_tuning_pkg::MILLER_FILTER_FAST_BIT];
            wide_q    <= cfg[rcv_tuning_pkg::WIDE_RECOVERY_LOOP_BIT];
            corner_q  <= corner_d;
            par_ins_q <= !parity_off;
            par_chk_q <= !parity_off;
            rx_bit_q  <= rx_bit_i;
            rx_val_q  <= rx_val_d;
            rx_err_q  <= rx_err_d;
        end
    end

    assign miller_filter_fast_o = fast_q;
    assign wide_recovery_loop_o = wide_q;
    assign highpass_corner_o    = corner_q;
    assign parity_insert_o      = par_ins_q;
    assign parity_check_o       = par_chk_q;
    assign secure_if_out_o      = sig_q;
    assign rx_data_bit_o        = rx_bit_q;
    assign rx_data_valid_o      = rx_val_q;
    assign rx_parity_error_o    = rx_err_q;
endmodule : receiver_manual_tuning_reg

// ===== tb/receiver_manual_tuning_reg_assertions.sv
`timescale 1ns/10ps
// Watches the bus answer and the control outputs of the register
module tuning_checker (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic [17:0] avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic [1:0]  rx_mode_i,
    input wire logic        miller_filter_fast_o,
    input wire logic        wide_recovery_loop_o,
    input wire logic [1:0]  highpass_corner_o,
    input wire logic        parity_insert_o,
    input wire logic        parity_check_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Write taken into the register
    sequence wr_acc;
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == rcv_tuning_pkg::MANUAL_RECEIVER_TUNING_ADDR;
    endsequence
    a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus answer late");
    a_fast_follow: assert property (wr_acc |-> ##2 miller_filter_fast_o ==
        $past(avs_writedata_i[6], 2)) else $error("fast filter wrong");
    a_loop_follow: assert property (wr_acc |-> ##2 wide_recovery_loop_o ==
        $past(avs_writedata_i[3], 2)) else $error("loop width wrong");
    a_parity_follow: assert property (wr_acc |-> ##2 parity_insert_o !=
        $past(avs_writedata_i[4], 2)) else $error("parity flag wrong");
    a_parity_pair: assert property (parity_insert_o == parity_check_o)
        else $error("parity flags differ");
    a_corner_manual: assert property (wr_acc ##0 avs_writedata_i[2] |-> ##2
        highpass_corner_o == $past(avs_writedata_i[1:0], 2)) else $error("manual corner");
    a_corner_auto: assert property (wr_acc ##0 !avs_writedata_i[2] |-> ##2
        highpass_corner_o == $past(rx_mode_i)) else $error("auto corner");
    a_unmapped_err: assert property (avs_read_i && avs_waitrequest_o &&
        avs_address_i != rcv_tuning_pkg::MANUAL_RECEIVER_TUNING_ADDR
        |=> avs_response_o == 2'h2 && avs_readdata_o == 32'h0) else $error("unmapped read");
    a_top_zero: assert property (avs_read_i && !avs_waitrequest_o |->
        avs_readdata_o[31:7] == 25'h0) else $error("reserved bits set");
endmodule : tuning_checker

bind receiver_manual_tuning_reg tuning_checker i_tuning_checker (.clock_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .rx_mode_i, .miller_filter_fast_o,
    .wide_recovery_loop_o, .highpass_corner_o, .parity_insert_o, .parity_check_o);

// ===== tb/receiver_manual_tuning_reg_tb.sv
`timescale 1ns/10ps
module receiver_manual_tuning_reg_tb;
    localparam logic [17:0] ADDR = rcv_tuning_pkg::MANUAL_RECEIVER_TUNING_ADDR;
    logic clock_i, rst_i, avs_read_i, avs_write_i, secure_if_raw_i, rx_bit_i, rx_bit_valid_i;
    logic rx_parity_slot_i, rx_parity_expected_i, miller_filter_fast_o, wide_recovery_loop_o;
    logic parity_insert_o, parity_check_o, secure_if_out_o, rx_data_bit_o, rx_data_valid_o;
    logic rx_parity_error_o, avs_waitrequest_o;
    logic [17:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd_q;
    logic [3:0]  avs_byteenable_i, signal_out_source_i;
    logic [1:0]  avs_response_o, rsp_q, rx_mode_i, tx_extra_wait_i, highpass_corner_o, m;
    logic [6:0]  tx_phase_delay_i;
    logic [7:0]  d;
    int bad_count, samples_checked, cyc;
    receiver_manual_tuning_reg i_receiver_manual_tuning_reg (.clock_i, .rst_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .avs_response_o, .signal_out_source_i, .rx_mode_i,
        .tx_phase_delay_i, .tx_extra_wait_i, .secure_if_raw_i, .rx_bit_i, .rx_bit_valid_i,
        .rx_parity_slot_i, .rx_parity_expected_i, .miller_filter_fast_o, .wide_recovery_loop_o,
        .highpass_corner_o, .parity_insert_o, .parity_check_o, .secure_if_out_o,
        .rx_data_bit_o, .rx_data_valid_o, .rx_parity_error_o);
    // Compare tasks, one per result kind
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    // Expected corner: manual field or receive mode
    function automatic logic [1:0] corner(input logic [7:0] v, input logic [1:0] md);
        return v[2] ? v[1:0] : md;
    endfunction : corner
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] v,
                       input logic [3:0] be);
        avs_address_i    <= a;
        avs_writedata_i  <= {24'h0, v};
        avs_byteenable_i <= be;
        avs_write_i      <= wr;
        avs_read_i       <= !wr;
        @(posedge clock_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
        rd_q = avs_readdata_o;
        rsp_q = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clock_i);
    endtask : bus
    // Cycles from a raw edge to its copy on the secure output
    task automatic lag(input logic v, input int exp);
        int n;
        n = 0;
        secure_if_raw_i <= v;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (secure_if_out_o !== v && n < 600);
        chk_val(32'(n), 32'(exp));
        @(posedge clock_i);
    endtask : lag
    // One received bit, then its outputs a cycle later
    task automatic rx(input logic s, input logic b, input logic e, input logic vo, input logic er);
        rx_bit_i <= b;
        rx_parity_slot_i <= s;
        rx_parity_expected_i <= e;
        rx_bit_valid_i <= 1'b1;
        @(posedge clock_i);
        rx_bit_valid_i <= 1'b0;
        #1;
        chk_bit(rx_data_valid_o, vo);
        chk_bit(rx_parity_error_o, er);
        chk_bit(rx_data_bit_o, b);
        @(posedge clock_i);
    endtask : rx
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        {avs_read_i, avs_write_i, secure_if_raw_i, rx_bit_i, rx_bit_valid_i} = '0;
        {rx_parity_slot_i, rx_parity_expected_i, avs_address_i, avs_writedata_i} = '0;
        {avs_byteenable_i, signal_out_source_i, rx_mode_i, tx_extra_wait_i} = '0;
        tx_phase_delay_i = '0;
        rst_i = 1'b1;
        void'($urandom(32'hcbd5));
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        bus(1'b0, ADDR, 8'h00, 4'hf);
        chk_val(rd_q, 32'h0);
        chk_bit(parity_insert_o, 1'b1);
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            m = 2'($urandom);
            if (i < 4) d = {d[7:3], 1'b1, 2'(i)};
            d[5] = 1'b0;
            rx_mode_i <= m;
            bus(1'b1, ADDR, d, 4'hf);
            bus(1'b0, ADDR, 8'h00, 4'hf);
            chk_val(rd_q, {24'h0, d & 8'h7f});
            chk_bit(miller_filter_fast_o, d[6]);
            chk_bit(wide_recovery_loop_o, d[3]);
            chk_bit(parity_check_o, !d[4]);
            chk_val(32'(highpass_corner_o), 32'(corner(d, m)));
        end
        bus(1'b1, ADDR, 8'h55, 4'h0);
        chk_val(32'(rsp_q), 32'h0);
        bus(1'b1, ADDR + 18'h4, 8'h2a, 4'hf);
        chk_val(32'(rsp_q), 32'h2);
        bus(1'b0, ADDR + 18'h4, 8'h00, 4'hf);
        chk_val(32'(rsp_q), 32'h2);
        chk_val(rd_q, 32'h0);
        bus(1'b0, ADDR, 8'h00, 4'hf);
        chk_val(rd_q, {24'h0, d & 8'h7f});
        bus(1'b1, ADDR, 8'h20, 4'hf);
        signal_out_source_i <= 4'hc;
        tx_phase_delay_i <= 7'h05;
        lag(1'b1, 6);
        lag(1'b0, 6);
        tx_extra_wait_i <= 2'h1;
        tx_phase_delay_i <= 7'h03;
        lag(1'b1, 132);
        bus(1'b1, ADDR, 8'h00, 4'hf);
        lag(1'b0, 1);
        // Card emulation source with delay on: output passes with no added delay
        signal_out_source_i <= 4'he;
        bus(1'b1, ADDR, 8'h20, 4'hf);
        lag(1'b1, 1);
        signal_out_source_i <= 4'h0;
        bus(1'b1, ADDR, 8'h00, 4'hf);
        bus(1'b0, ADDR, 8'h00, 4'hf);
        chk_val(rd_q, 32'h0);
        rx(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        rx(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        bus(1'b1, ADDR, 8'h10, 4'hf);
        rx(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        results();
    end
endmodule : receiver_manual_tuning_reg_tb
